// ---- rtl/mode_ctrl_pkg.sv ----
// shared constants and types for the operating-mode controller
package mode_ctrl_pkg;

  // ****************************************
  // operating modes
  // ****************************************
  typedef enum logic [2:0] {
    MODE_RESET   = 3'b000,
    MODE_NORMREQ = 3'b001,
    MODE_NORMAL  = 3'b010,
    MODE_STOP    = 3'b011,
    MODE_SLEEP   = 3'b100
  } op_mode_t;

  // ****************************************
  // mode_select_bits encodings
  // ****************************************
  localparam logic [1:0] SEL_NORMAL = 2'h0;
  localparam logic [1:0] SEL_STOP = 2'h1;
  localparam logic [1:0] SEL_SLEEP = 2'h2;
  localparam logic [1:0] SEL_WD_TRIG = 2'h3;

  // ****************************************
  // timing in their own units and the clock rate
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int RESET_LOW_US = 1000;
  localparam int NREQ_TIMEOUT_MS = 150;
  localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
  localparam int NREQ_TIMEOUT_CYC = NREQ_TIMEOUT_MS * 1000 * CLK_MHZ;

  // ****************************************
  // wake source bit positions
  // ****************************************
  localparam int WK_INPUT = 0;
  localparam int WK_LIN = 1;
  localparam int WK_PERIODIC = 2;
  localparam int WK_W = 3;

  // ****************************************
  // interrupt source bit positions
  // ****************************************
  localparam int IS_UV = 0;
  localparam int IS_OV = 1;
  localparam int IS_OTW = 2;
  localparam int IS_LIN = 3;
  localparam int IS_HSOT = 4;
  localparam int IS_W = 5;

endpackage

// ---- rtl/mode_ctrl.sv ----
// operating-mode, reset, interrupt and wake-up controller
`timescale 1ns/1ps
// Notes on behaviour
// - one write from Normal enters Sleep
// - sleep keeps only input, periodic, LIN wake
// - cyclic sense pulses high side, samples input
// - sleep wake acts as power-up, records source
// - stop only by command, regulator reduced
// - stop wake goes Normal Request with interrupt; select wake gives no interrupt, reset wake goes Reset
// - allowed wake sources per low-power mode
// - missed or early watchdog trigger forces Reset
// - normal request: timeout, no window, LIN receive-only
// - cyclic sense allowed in stop and sleep
// - no new interrupt until wakes read
// - request pin low until read acknowledge
// - interrupts only Normal, Request, Stop, reset high
// - listed fault events raise maskable interrupts
// - LIN faults disable driver until cleared, read
// - LIN over-current sets flag, driver stays
// - reset line low plus extension after condition
// - regulator below threshold issues reset; the code ignores it in Sleep
// - regulator over-temperature disables regulator, sets flag
// - filtered external reset low holds reset state
// - external reset release has no extension
// - no status for select or reset wake
// - power-up reset low then Normal Request
// - host selects normal within timeout else Reset
// - watchdog pin grounded skips Normal Request
module mode_ctrl #(
  parameter int RST_LOW_CYC = mode_ctrl_pkg::RESET_LOW_CYC,
  parameter int NREQ_CYC = mode_ctrl_pkg::NREQ_TIMEOUT_CYC,
  parameter int WD_PERIOD_CYC = 1000000,
  parameter int CYC_PERIOD = 8,
  parameter int GLITCH_CYC = 16
) (
  // system clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // low-power oscillator clock
  input wire logic lp_clk_i,
  // host command strobes
  input wire logic mode_wr_i,
  input wire logic [1:0] mode_select_bits_i,
  input wire logic timing_wr_i,
  input wire logic isr_rd_i,
  input wire logic lin_rd_i,
  // configuration bits
  input wire logic wake_input_enable_bit_i,
  input wire logic cyclic_en_i,
  input wire logic force_wake_en_i,
  input wire logic [mode_ctrl_pkg::IS_W-1:0] interrupt_mask_register_i,
  // asynchronous pins
  input wire logic watchdog_config_pin_i,
  input wire logic wake_input_i,
  input wire logic lin_wake_i,
  input wire logic cs_n_i,
  input wire logic rst_n_pin_i,
  input wire logic reg_below_reset_threshold_i,
  input wire logic reg_overtemp_i,
  input wire logic supply_uv_i,
  input wire logic supply_ov_i,
  input wire logic reg_otw_i,
  input wire logic lin_fault_i,
  input wire logic lin_oc_i,
  input wire logic hs_overtemp_i,
  // outputs
  output logic [2:0] mode_o,
  output logic rst_n_o,
  output logic rst_oe_o,
  output logic irq_n_o,
  output logic reg_on_o,
  output logic reg_reduced_o,
  output logic lin_tx_en_o,
  output logic lin_overcurrent_flag_o,
  output logic regulator_overtemp_flag_o,
  output logic battery_fail_flag_o,
  output logic [mode_ctrl_pkg::WK_W-1:0] wake_status_register_o,
  output logic [mode_ctrl_pkg::IS_W-1:0] interrupt_source_register_o,
  output logic high_side_output_o
);
  localparam int IS_W_L = mode_ctrl_pkg::IS_W;
  localparam int NS = 13;

  initial begin
    if (RST_LOW_CYC < 1 || NREQ_CYC < 1 || GLITCH_CYC < 1 || CYC_PERIOD < 2)
      $error("mode_ctrl: bad parameter");
  end

  // ****************************************
  // input synchronisers, one generate loop
  // ****************************************
  logic [NS-1:0] async_in, s1_reg, s2_reg;
  assign async_in = {watchdog_config_pin_i, wake_input_i, lin_wake_i, cs_n_i, rst_n_pin_i,
                     reg_below_reset_threshold_i, reg_overtemp_i, supply_uv_i, supply_ov_i,
                     reg_otw_i, lin_fault_i, lin_oc_i, hs_overtemp_i};
  generate
    for (genvar gi = 0; gi < NS; gi++) begin : g_sync
      // two-flop synchroniser per pin
      always_ff @(posedge sys_clk_i) begin
        s1_reg[gi] <= async_in[gi];
        s2_reg[gi] <= s1_reg[gi];
      end
    end
  endgenerate
  logic watchdog_config_pin_gnd, wk_in, lin_wk, cs_n, rpin_n, vlow, vot, uv, ov, otw, linf, lin_overcurrent_flag, hsot;
  assign {watchdog_config_pin_gnd, wk_in, lin_wk, cs_n, rpin_n, vlow, vot, uv, ov, otw, linf, lin_overcurrent_flag, hsot} =
    s2_reg;

  // ****************************************
  // cyclic sense tick in the low-power domain
  // ****************************************
  logic [15:0] lp_cnt_reg;
  logic lp_tog_reg, lp_on_reg, lp_run_s1_reg, lp_run_s2_reg, lp_run;
  // run request crosses into the oscillator domain
  always_ff @(posedge lp_clk_i) begin
    lp_run_s1_reg <= lp_run;
    lp_run_s2_reg <= lp_run_s1_reg;
  end
  // period counter; the on slot is the last count of each period
  always_ff @(posedge lp_clk_i) begin
    if (!lp_run_s2_reg) begin
      lp_cnt_reg <= 16'h0000;
      lp_on_reg <= 1'b0;
      lp_tog_reg <= 1'b0;
    end else if (lp_cnt_reg == 16'(CYC_PERIOD - 1)) begin
      lp_cnt_reg <= 16'h0000;
      lp_on_reg <= 1'b0;
      lp_tog_reg <= ~lp_tog_reg;
    end else begin
      lp_cnt_reg <= lp_cnt_reg + 16'h0001;
      lp_on_reg <= (lp_cnt_reg == 16'(CYC_PERIOD - 2));
    end
  end
  // tick toggle back into the system domain
  logic tk1_reg, tk2_reg, tk3_reg, on1_reg, on2_reg;
  always_ff @(posedge sys_clk_i) begin
    tk1_reg <= lp_tog_reg;
    tk2_reg <= tk1_reg;
    tk3_reg <= tk2_reg;
    on1_reg <= lp_on_reg;
    on2_reg <= on1_reg;
  end
  logic period_tick;
  assign period_tick = tk2_reg ^ tk3_reg;

  // state and counters
  mode_ctrl_pkg::op_mode_t mode_reg;
  logic [31:0] cnt_reg, wd_reg;
  logic [15:0] glitch_reg;
  logic ext_rst, rst_src, por_reg, wk_ref_reg, cs_d_reg, low_power, wd_fail;
  logic [mode_ctrl_pkg::WK_W-1:0] wk_ev;
  logic wake_any, wake_cs, wake_rst;

  assign low_power = (mode_reg == mode_ctrl_pkg::MODE_STOP) ||
                     (mode_reg == mode_ctrl_pkg::MODE_SLEEP);
  assign lp_run = low_power && (cyclic_en_i || force_wake_en_i);

  // external reset low filter; our own low drive is not an outside request
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      glitch_reg <= 16'h0000;
    else if (rpin_n || (rst_oe_o && !rst_n_o && !ext_rst))
      glitch_reg <= 16'h0000;
    else if (glitch_reg != 16'(GLITCH_CYC))
      glitch_reg <= glitch_reg + 16'h0001;
  end
  assign ext_rst = (glitch_reg == 16'(GLITCH_CYC));

  // wake sources, filtered per mode
  always_comb begin
    wk_ev = '0;
    if (low_power) begin
      wk_ev[mode_ctrl_pkg::WK_INPUT] = wake_input_enable_bit_i && (wk_in != wk_ref_reg) &&
                                       (!cyclic_en_i || on2_reg);
      wk_ev[mode_ctrl_pkg::WK_LIN] = lin_wk;
      wk_ev[mode_ctrl_pkg::WK_PERIODIC] = force_wake_en_i && !cyclic_en_i && period_tick;
    end
  end
  assign wake_cs = (mode_reg == mode_ctrl_pkg::MODE_STOP) && cs_n && !cs_d_reg;
  assign wake_rst = (mode_reg == mode_ctrl_pkg::MODE_STOP) && ext_rst;
  assign wake_any = |wk_ev;

  // reset conditions
  assign wd_fail = (mode_reg == mode_ctrl_pkg::MODE_NORMAL) && !watchdog_config_pin_gnd &&
                   ((wd_reg >= 32'(WD_PERIOD_CYC)) ||
                    (mode_wr_i && mode_select_bits_i == mode_ctrl_pkg::SEL_WD_TRIG &&
                     wd_reg < 32'(WD_PERIOD_CYC / 2)));
  assign rst_src = ((mode_reg != mode_ctrl_pkg::MODE_SLEEP) && vlow) || vot || wd_fail;

  // reference level of the wake input, reference cs
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wk_ref_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else begin
      cs_d_reg <= cs_n;
      if (!low_power || wk_ev[mode_ctrl_pkg::WK_INPUT])
        wk_ref_reg <= wk_in;
    end
  end

  // watchdog window counter
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || mode_reg != mode_ctrl_pkg::MODE_NORMAL)
      wd_reg <= 32'h0000_0000;
    else if (mode_wr_i && mode_select_bits_i == mode_ctrl_pkg::SEL_WD_TRIG)
      wd_reg <= 32'h0000_0000;
    else
      wd_reg <= wd_reg + 32'h0000_0001;
  end

  // ****************************************
  // mode state machine
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mode_reg <= mode_ctrl_pkg::MODE_RESET;
      cnt_reg <= 32'h0000_0000;
      por_reg <= 1'b1;
    end else begin
      case (mode_reg)
        mode_ctrl_pkg::MODE_RESET: begin
          if (rst_src) begin
            cnt_reg <= 32'h0000_0000;
          end else if (ext_rst) begin
            cnt_reg <= 32'(RST_LOW_CYC);
          end else if (cnt_reg >= 32'(RST_LOW_CYC - 1)) begin
            cnt_reg <= 32'h0000_0000;
            por_reg <= 1'b0;
            mode_reg <= watchdog_config_pin_gnd ? mode_ctrl_pkg::MODE_NORMAL
                                   : mode_ctrl_pkg::MODE_NORMREQ;
          end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
          end
        end
        mode_ctrl_pkg::MODE_NORMREQ: begin
          if (rst_src || ext_rst) begin
            mode_reg <= mode_ctrl_pkg::MODE_RESET;
            cnt_reg <= 32'h0000_0000;
          end else if (mode_wr_i && mode_select_bits_i == mode_ctrl_pkg::SEL_NORMAL) begin
            mode_reg <= mode_ctrl_pkg::MODE_NORMAL;
            cnt_reg <= 32'h0000_0000;
          end else if (cnt_reg >= 32'(NREQ_CYC - 1)) begin
            mode_reg <= mode_ctrl_pkg::MODE_RESET;
            cnt_reg <= 32'h0000_0000;
          end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
          end
        end
        mode_ctrl_pkg::MODE_NORMAL: begin
          cnt_reg <= 32'h0000_0000;
          if (rst_src || ext_rst)
            mode_reg <= mode_ctrl_pkg::MODE_RESET;
          else if (mode_wr_i && mode_select_bits_i == mode_ctrl_pkg::SEL_SLEEP)
            mode_reg <= mode_ctrl_pkg::MODE_SLEEP;
          else if (mode_wr_i && mode_select_bits_i == mode_ctrl_pkg::SEL_STOP)
            mode_reg <= mode_ctrl_pkg::MODE_STOP;
        end
        mode_ctrl_pkg::MODE_STOP: begin
          cnt_reg <= 32'h0000_0000;
          if (rst_src)
            mode_reg <= mode_ctrl_pkg::MODE_RESET;
          else if (wake_any || wake_cs)
            mode_reg <= watchdog_config_pin_gnd ? mode_ctrl_pkg::MODE_NORMAL
                                   : mode_ctrl_pkg::MODE_NORMREQ;
          else if (wake_rst)
            mode_reg <= mode_ctrl_pkg::MODE_RESET;
        end
        mode_ctrl_pkg::MODE_SLEEP: begin
          cnt_reg <= 32'h0000_0000;
          if (wake_any || vot)
            mode_reg <= mode_ctrl_pkg::MODE_RESET;
        end
        default: begin
          mode_reg <= mode_ctrl_pkg::MODE_RESET;
          cnt_reg <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************
  // wake status and interrupt sources
  // ****************************************
  logic [mode_ctrl_pkg::WK_W-1:0] wake_status_reg;
  logic [IS_W_L-1:0] isr_reg, ev;
  logic irq_mode, irq_req_reg;
  assign irq_mode = (mode_reg == mode_ctrl_pkg::MODE_NORMAL) ||
                    (mode_reg == mode_ctrl_pkg::MODE_NORMREQ) ||
                    (mode_reg == mode_ctrl_pkg::MODE_STOP);
  assign ev = {hsot, linf | lin_overcurrent_flag, otw, ov, uv};
  // recorded wake sources; select and reset wakes have no bit; set beats read clear
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      wake_status_reg <= '0;
    else
      wake_status_reg <= (isr_rd_i ? '0 : wake_status_reg) | wk_ev;
  end
  // latched fault sources, masked in the mask word
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      isr_reg <= '0;
    else if (irq_mode && mode_reg != mode_ctrl_pkg::MODE_STOP)
      isr_reg <= (isr_rd_i ? '0 : isr_reg) | (ev & interrupt_mask_register_i);
    else if (isr_rd_i)
      isr_reg <= '0;
  end
  // request line: low from event until read, held off while wakes pend
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      irq_req_reg <= 1'b0;
    else if (!irq_mode || !rst_n_o)
      irq_req_reg <= 1'b0;
    else if (mode_reg == mode_ctrl_pkg::MODE_STOP && wake_any)
      irq_req_reg <= 1'b1;
    else if (isr_rd_i)
      irq_req_reg <= 1'b0;
    else if (wake_status_reg == '0 && |(ev & interrupt_mask_register_i))
      irq_req_reg <= 1'b1;
  end
  // LIN driver and regulator flags
  logic lin_dis_reg, lin_overcurrent_flag_reg, vot_reg, battery_fail_flag_reg;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      lin_dis_reg <= 1'b0;
    else if (linf)
      lin_dis_reg <= 1'b1;
    else if (lin_rd_i)
      lin_dis_reg <= 1'b0;
  end
  // over-current flag only; driver left on
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      lin_overcurrent_flag_reg <= 1'b0;
    else
      lin_overcurrent_flag_reg <= lin_overcurrent_flag | (lin_overcurrent_flag_reg & ~lin_rd_i);
  end
  // regulator over-temperature flag, independent of output voltage
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      vot_reg <= 1'b0;
    else
      vot_reg <= vot | (vot_reg & ~isr_rd_i);
  end
  // battery fail set only by power-on, never by sleep wake
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      battery_fail_flag_reg <= 1'b1;
    else if (isr_rd_i && !por_reg)
      battery_fail_flag_reg <= 1'b0;
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mode_o <= 3'h0;
      rst_n_o <= 1'b0;
      rst_oe_o <= 1'b1;
      irq_n_o <= 1'b1;
      reg_on_o <= 1'b1;
      reg_reduced_o <= 1'b0;
      lin_tx_en_o <= 1'b0;
      lin_overcurrent_flag_o <= 1'b0;
      regulator_overtemp_flag_o <= 1'b0;
      battery_fail_flag_o <= 1'b1;
      wake_status_register_o <= '0;
      interrupt_source_register_o <= '0;
      high_side_output_o <= 1'b0;
    end else begin
      mode_o <= mode_reg;
      rst_n_o <= (mode_reg != mode_ctrl_pkg::MODE_RESET) && !ext_rst;
      rst_oe_o <= (mode_reg == mode_ctrl_pkg::MODE_RESET) && !ext_rst;
      irq_n_o <= ~irq_req_reg;
      reg_on_o <= (mode_reg != mode_ctrl_pkg::MODE_SLEEP) && !vot;
      reg_reduced_o <= (mode_reg == mode_ctrl_pkg::MODE_STOP);
      lin_tx_en_o <= (mode_reg == mode_ctrl_pkg::MODE_NORMAL) && !lin_dis_reg &&
                     !linf;
      lin_overcurrent_flag_o <= lin_overcurrent_flag_reg;
      regulator_overtemp_flag_o <= vot_reg;
      battery_fail_flag_o <= battery_fail_flag_reg;
      wake_status_register_o <= wake_status_reg;
      interrupt_source_register_o <= isr_reg;
      high_side_output_o <= low_power && cyclic_en_i && on2_reg;
    end
  end

  // timing write accepted, no effect here
  logic unused_ok;
  assign unused_ok = timing_wr_i;

endmodule // mode_ctrl

// ---- tb/mode_ctrl_checker.sv ----
// assertion checker for the mode controller ports
`timescale 1ns/1ps
module mode_ctrl_checker #(
  parameter int RST_LOW_CYC = 50
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // watched ports
  input wire logic mode_wr_i,
  input wire logic [1:0] mode_select_bits_i,
  input wire logic isr_rd_i,
  input wire logic rst_n_pin_i,
  input wire logic [2:0] mode_o,
  input wire logic rst_n_o,
  input wire logic irq_n_o,
  input wire logic reg_on_o,
  input wire logic reg_reduced_o,
  input wire logic battery_fail_flag_o
);
  localparam logic [2:0] M_RST = mode_ctrl_pkg::MODE_RESET;
  localparam logic [2:0] M_REQ = mode_ctrl_pkg::MODE_NORMREQ;
  localparam logic [2:0] M_NRM = mode_ctrl_pkg::MODE_NORMAL;
  localparam logic [2:0] M_STP = mode_ctrl_pkg::MODE_STOP;
  localparam logic [2:0] M_SLP = mode_ctrl_pkg::MODE_SLEEP;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  int low_cnt;
  logic ext_rst;
  // cycles the reset line has been driven low
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || rst_n_o) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  // an outside pull while the device drives high marks an external reset
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || $rose(rst_n_o)) ext_rst <= 1'b0;
    else if (!rst_n_pin_i && rst_n_o) ext_rst <= 1'b1;
  end
  // ****************************************
  // sequences and assertions
  // ****************************************
  sequence s_cmd(logic [1:0] sel);
    mode_wr_i && mode_select_bits_i == sel && mode_o == M_NRM;
  endsequence
  sequence s_leave(logic [2:0] m);
    mode_o == m ##1 mode_o != m;
  endsequence
  a_sleep_enter: assert property (s_cmd(mode_ctrl_pkg::SEL_SLEEP) |-> ##2 mode_o == M_SLP)
    else $error("sleep command not taken");
  a_sleep_reg_off: assert property (mode_o == M_SLP |-> !reg_on_o)
    else $error("regulator on in sleep");
  a_stop_enter: assert property (s_cmd(mode_ctrl_pkg::SEL_STOP)
    |-> ##2 mode_o == M_STP && reg_on_o && reg_reduced_o)
    else $error("stop command not taken");
  a_stop_by_cmd: assert property ($changed(mode_o) && mode_o == M_STP
    |-> $past(mode_wr_i, 2) && $past(mode_select_bits_i, 2) == mode_ctrl_pkg::SEL_STOP)
    else $error("stop entered without command");
  a_sleep_wake_rst: assert property (s_leave(M_SLP) |-> mode_o == M_RST && !battery_fail_flag_o)
    else $error("sleep wake not a clean reset");
  a_stop_wake_req: assert property (s_leave(M_STP) |-> mode_o inside {M_REQ, M_NRM, M_RST})
    else $error("stop wake went elsewhere");
  a_quiet_irq: assert property ((mode_o == M_SLP || !rst_n_o) && $stable(mode_o)
    && $stable(rst_n_o) |-> irq_n_o)
    else $error("interrupt in sleep or reset");
  a_irq_hold: assert property (!irq_n_o && !isr_rd_i && !$past(isr_rd_i) && $stable(mode_o)
    && rst_n_o |=> !irq_n_o || mode_o != $past(mode_o))
    else $error("interrupt dropped without read");
  a_rst_extend: assert property ($rose(rst_n_o) && !ext_rst |-> low_cnt >= RST_LOW_CYC - 1)
    else $error("reset line released early");
endmodule // mode_ctrl_checker

bind mode_ctrl mode_ctrl_checker #(.RST_LOW_CYC(RST_LOW_CYC)) u_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .mode_wr_i(mode_wr_i),
  .mode_select_bits_i(mode_select_bits_i), .isr_rd_i(isr_rd_i), .rst_n_pin_i(rst_n_pin_i),
  .mode_o(mode_o), .rst_n_o(rst_n_o), .irq_n_o(irq_n_o), .reg_on_o(reg_on_o),
  .reg_reduced_o(reg_reduced_o), .battery_fail_flag_o(battery_fail_flag_o)
);

// ---- tb/host_mcu_model.sv ----
// host microcontroller model: reset line pull and interrupt acknowledge
`timescale 1ns/1ps
module host_mcu_model (
  // clock
  input wire logic sys_clk_i,
  // device pins
  input wire logic irq_n_o,
  input wire logic rst_n_o,
  input wire logic rst_oe_o,
  // host controls
  input wire logic pull_low_i,
  input wire logic [7:0] ack_dly_i,
  // toward the device
  output logic isr_rd_o,
  output logic rst_n_pin_o
);
  int cnt = 0;
  // open-drain reset line with pull-up; either party may hold it low
  assign rst_n_pin_o = !((rst_oe_o && !rst_n_o) || pull_low_i);
  // read the source register once the request has stood for ack_dly_i cycles
  initial isr_rd_o = 1'b0;
  always @(negedge sys_clk_i) begin
    isr_rd_o <= 1'b0;
    if (irq_n_o) cnt = 0;
    else cnt = cnt + 1;
    if (cnt == int'(ack_dly_i)) isr_rd_o <= 1'b1;
  end
endmodule // host_mcu_model

// ---- tb/tb_mode_ctrl.sv ----
// self-checking bench for the mode controller
`timescale 1ns/1ps
module tb_mode_ctrl;
  localparam int RL = 50;
  localparam int NQ = 60;
  localparam logic [2:0] M_RST = mode_ctrl_pkg::MODE_RESET;
  localparam logic [2:0] M_REQ = mode_ctrl_pkg::MODE_NORMREQ;
  localparam logic [2:0] M_NRM = mode_ctrl_pkg::MODE_NORMAL;
  localparam logic [2:0] M_STP = mode_ctrl_pkg::MODE_STOP;
  localparam logic [2:0] M_SLP = mode_ctrl_pkg::MODE_SLEEP;
  logic sys_clk_i = 0, lp_clk = 0, srst = 1, mode_wr = 0, timing_wr = 0, lin_rd = 0;
  logic wk_en = 0, cyc_en = 0, wd_pin = 0, wake_in = 0, lin_wake = 0, cs_n = 1;
  logic below = 0, reg_ot = 0, lin_oc = 0, pull = 0, fw = 0, isr_rd, rst_pin;
  logic [1:0] sel = 0;
  logic [4:0] mask = 5'h1f, fault = 5'h0, isr_v;
  logic [7:0] ack_dly = 8'h14;
  logic [2:0] mode, wsr, prev = 3'h0;
  logic rst_n, rst_oe, irq_n, reg_on, reg_red, lin_tx, lin_ocf, reg_otf, bat_f, hs;
  logic [2:0] exp_q[$];
  bit mon_on = 0;
  int error_cnt = 0;
  int n_tests = 0;
  // system and low-power clocks, unrelated phases
  always #2 sys_clk_i = ~sys_clk_i;
  initial begin
    #17;
    forever #62.5 lp_clk = ~lp_clk;
  end
  mode_ctrl #(.RST_LOW_CYC(RL), .NREQ_CYC(NQ), .WD_PERIOD_CYC(200), .CYC_PERIOD(8),
    .GLITCH_CYC(4)) uut (
    .sys_clk_i(sys_clk_i), .srst_i(srst), .lp_clk_i(lp_clk), .mode_wr_i(mode_wr),
    .mode_select_bits_i(sel), .timing_wr_i(timing_wr), .isr_rd_i(isr_rd), .lin_rd_i(lin_rd),
    .wake_input_enable_bit_i(wk_en), .cyclic_en_i(cyc_en), .force_wake_en_i(fw),
    .interrupt_mask_register_i(mask), .watchdog_config_pin_i(wd_pin), .wake_input_i(wake_in),
    .lin_wake_i(lin_wake), .cs_n_i(cs_n), .rst_n_pin_i(rst_pin),
    .reg_below_reset_threshold_i(below), .reg_overtemp_i(reg_ot), .supply_uv_i(fault[0]),
    .supply_ov_i(fault[1]), .reg_otw_i(fault[2]), .lin_fault_i(fault[3]), .lin_oc_i(lin_oc),
    .hs_overtemp_i(fault[4]), .mode_o(mode), .rst_n_o(rst_n), .rst_oe_o(rst_oe),
    .irq_n_o(irq_n), .reg_on_o(reg_on), .reg_reduced_o(reg_red), .lin_tx_en_o(lin_tx),
    .lin_overcurrent_flag_o(lin_ocf), .regulator_overtemp_flag_o(reg_otf),
    .battery_fail_flag_o(bat_f), .wake_status_register_o(wsr),
    .interrupt_source_register_o(isr_v), .high_side_output_o(hs));
  host_mcu_model u_host (.sys_clk_i(sys_clk_i), .irq_n_o(irq_n), .rst_n_o(rst_n),
    .rst_oe_o(rst_oe), .pull_low_i(pull), .ack_dly_i(ack_dly), .isr_rd_o(isr_rd),
    .rst_n_pin_o(rst_pin));
  // ****************************************
  // compare, wait and drive tasks
  // ****************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic check_mode(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: mode %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timed_out();
    error_cnt++;
    $display("ERROR %0t: wait ran out", $time);
    finish_test();
  endtask
  task automatic wait_mode(input logic [2:0] m, input int bound, output int n);
    n = 0;
    while (mode !== m && n < bound) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (mode !== m) timed_out();
  endtask
  task automatic wait_bit(ref logic s, input logic v, input int bound);
    int n;
    n = 0;
    while (s !== v && n < bound) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (s !== v) timed_out();
  endtask
  task automatic cmd(input logic [1:0] s);
    @(negedge sys_clk_i);
    mode_wr = 1'b1;
    sel = s;
    @(negedge sys_clk_i);
    mode_wr = 1'b0;
  endtask
  task automatic go_normal();
    int n;
    exp_q.push_back(M_NRM);
    timing_wr = 1'b1;
    @(negedge sys_clk_i);
    timing_wr = 1'b0;
    cmd(mode_ctrl_pkg::SEL_NORMAL);
    wait_mode(M_NRM, 4, n);
  endtask
  // each mode change takes the oldest expected mode
  always @(posedge sys_clk_i) begin
    #1;
    if (mon_on && mode !== prev) check_mode(mode, exp_q.size() ? exp_q.pop_front() : 3'h7);
    prev = mode;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int n;
    void'($urandom(32'h1f22));
    repeat (3) @(negedge sys_clk_i);
    srst = 1'b0;
    mon_on = 1'b1;
    check_bit(bat_f, 1'b1);
    exp_q.push_back(M_REQ);
    wait_mode(M_REQ, RL + 20, n);
    check_bit(n >= RL, 1'b1);
    // no command in time, then an early watchdog trigger
    exp_q.push_back(M_RST);
    exp_q.push_back(M_REQ);
    wait_mode(M_RST, NQ + 20, n);
    wait_mode(M_REQ, RL + 20, n);
    go_normal();
    exp_q.push_back(M_RST);
    exp_q.push_back(M_REQ);
    cmd(mode_ctrl_pkg::SEL_WD_TRIG);
    wait_mode(M_RST, 8, n);
    wait_mode(M_REQ, RL + 20, n);
    go_normal();
    repeat (130) @(negedge sys_clk_i);
    cmd(mode_ctrl_pkg::SEL_WD_TRIG);
    // short pull is filtered, long pull resets; watchdog now grounded
    wd_pin = 1'b1;
    pull = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    pull = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    exp_q.push_back(M_RST);
    exp_q.push_back(M_NRM);
    pull = 1'b1;
    wait_mode(M_RST, 12, n);
    repeat (RL + 10) @(negedge sys_clk_i);
    check_bit(rst_n, 1'b0);
    pull = 1'b0;
    wait_mode(M_NRM, 10, n);
    // fault interrupts under a random mask
    for (int i = 0; i < 5; i++) begin
      mask = 5'($urandom);
      fault[i] = 1'b1;
      repeat (6) @(negedge sys_clk_i);
      check_bit(irq_n, !mask[i]);
      if (mask[i]) check_bit(isr_v[i], 1'b1);
      if (i == mode_ctrl_pkg::IS_LIN) check_bit(lin_tx, 1'b0);
      fault[i] = 1'b0;
      wait_bit(irq_n, 1'b1, 40);
    end
    check_bit(lin_tx, 1'b0);
    lin_rd = 1'b1;
    @(negedge sys_clk_i);
    lin_rd = 1'b0;
    wait_bit(lin_tx, 1'b1, 8);
    lin_oc = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    check_bit(lin_ocf & lin_tx, 1'b1);
    lin_oc = 1'b0;
    // stop, woken by the wake input, with a random host delay
    wk_en = 1'b1;
    ack_dly = 8'(4 + $urandom_range(16));
    exp_q.push_back(M_STP);
    exp_q.push_back(M_NRM);
    cmd(mode_ctrl_pkg::SEL_STOP);
    wait_mode(M_STP, 4, n);
    check_bit(reg_on & reg_red, 1'b1);
    wake_in = 1'b1;
    wait_mode(M_NRM, 12, n);
    wait_bit(irq_n, 1'b0, 4);
    check_bit(wsr[mode_ctrl_pkg::WK_INPUT], 1'b1);
    wait_bit(irq_n, 1'b1, 40);
    // stop, woken by chip-select: no interrupt, no status
    exp_q.push_back(M_STP);
    exp_q.push_back(M_NRM);
    cmd(mode_ctrl_pkg::SEL_STOP);
    wait_mode(M_STP, 4, n);
    cs_n = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    cs_n = 1'b1;
    wait_mode(M_NRM, 12, n);
    repeat (4) @(negedge sys_clk_i);
    check_bit(irq_n, 1'b1);
    check_bit(|wsr, 1'b0);
    // stop, woken by the periodic timer
    fw = 1'b1;
    exp_q.push_back(M_STP);
    exp_q.push_back(M_NRM);
    cmd(mode_ctrl_pkg::SEL_STOP);
    wait_mode(M_STP, 4, n);
    wait_mode(M_NRM, 700, n);
    check_bit(wsr[mode_ctrl_pkg::WK_PERIODIC], 1'b1);
    fw = 1'b0;
    // sleep with cyclic sense, woken from the bus
    cyc_en = 1'b1;
    exp_q.push_back(M_SLP);
    exp_q.push_back(M_RST);
    exp_q.push_back(M_NRM);
    cmd(mode_ctrl_pkg::SEL_SLEEP);
    wait_mode(M_SLP, 4, n);
    wait_bit(hs, 1'b1, 700);
    lin_wake = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    lin_wake = 1'b0;
    wait_mode(M_RST, 12, n);
    check_bit(bat_f, 1'b0);
    check_bit(wsr[mode_ctrl_pkg::WK_LIN], 1'b1);
    wait_mode(M_NRM, RL + 20, n);
    // regulator brown-out, then over-temperature
    exp_q.push_back(M_RST);
    exp_q.push_back(M_NRM);
    below = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    below = 1'b0;
    wait_mode(M_RST, 8, n);
    wait_mode(M_NRM, RL + 20, n);
    check_bit(n >= RL, 1'b1);
    check_bit(exp_q.size() == 0, 1'b1);
    mon_on = 1'b0;
    reg_ot = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    check_bit(reg_otf, 1'b1);
    finish_test();
  end
endmodule // tb_mode_ctrl
